// ### rtl/asr_dev.sv
// Converter end: conversion cycle, status flag and 32-bit serial readout
`timescale 1ns/1ps
`include "asr_params.svh"
module asr_dev #(
    parameter int unsigned POR_CYCLES  = `ASR_POR_CYC,
    parameter int unsigned CONV_CYCLES = `ASR_CONV_CYC
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // Link
    asr_link_if.dev          lk,
    // Conversion result from the datapath, sampled at conversion end
    input  wire logic [30:0] i_result,
    // Status
    output logic             o_busy,
    output logic             o_ext_sck,
    output logic             o_frame_done
);

    asr_pkg::asr_dev_state_e         state_q;
    logic [`ASR_TIMER_W-1:0]         timer_q;
    logic [`ASR_CNT_W-1:0]           rise_cnt_q;
    logic [`ASR_FRAME_BITS-1:0]      shreg_q;
    logic                            ext_q;
    logic                            sck_lvl_q;
    logic                            pullup_q;
    logic                            sdo_q;
    logic                            sdo_oe_q;
    logic                            sck_oe_q;
    logic                            sck_o_q;
    logic                            busy_q;
    logic                            done_q;
    logic                            cs_m_q, cs_s_q, cs_p_q;
    logic                            sck_m_q, sck_s_q, sck_p_q;
    logic                            cs_fall, cs_rise;
    logic                            sck_rise, sck_fall;
    logic                            por_end;
    logic                            frame_full;

    // Timer end test shared by the timed states
    function automatic logic hit(input logic [`ASR_TIMER_W-1:0] t, input int unsigned n);
        hit = (t == `ASR_TIMER_W'(n - 1));
    endfunction

    // Rising edge of a synchronised level
    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction

    // Pin inputs pass two flip-flops, then a third keeps the previous level
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
            cs_p_q  <= 1'b1;
            sck_m_q <= 1'b1;
            sck_s_q <= 1'b1;
            sck_p_q <= 1'b1;
        end else begin
            cs_m_q  <= lk.cs_n;
            cs_s_q  <= cs_m_q;
            cs_p_q  <= cs_s_q;
            sck_m_q <= lk.sck;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
        end
    end

    assign cs_fall    = rise(cs_p_q, cs_s_q);
    assign cs_rise    = rise(cs_s_q, cs_p_q);
    assign sck_rise   = rise(sck_s_q, sck_p_q);
    assign sck_fall   = rise(sck_p_q, sck_s_q);
    assign por_end    = (state_q == asr_pkg::ASR_D_POR) && hit(timer_q, POR_CYCLES);
    assign frame_full = (rise_cnt_q == `ASR_CNT_W'(`ASR_FRAME_BITS));

    // Clock source choice: caught at power-up end and at every select fall
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_q <= 1'b0;
        end else if (por_end) begin
            ext_q <= ~sck_s_q;                          // Low SCK at power-up end picks external
        end else if (cs_fall) begin
            ext_q <= ~sck_s_q;                          // Low SCK at select fall picks external
        end
    end

    // Weak pull-up: dropped when SCK falls, restored when SCK rises or an internally clocked status check ends in sleep
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pullup_q <= 1'b1;
        end else if (cs_rise && state_q == asr_pkg::ASR_D_SLEEP && !ext_q) begin
            pullup_q <= 1'b1;
        end else if (sck_fall) begin
            pullup_q <= 1'b0;
        end else if (sck_rise || state_q == asr_pkg::ASR_D_POR) begin
            pullup_q <= 1'b1;                           // Held on while SCK high, so on at select fall
        end
    end

    // Conversion, sleep and output sequencing
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q    <= asr_pkg::ASR_D_POR;
            timer_q    <= '0;
            rise_cnt_q <= '0;
            shreg_q    <= '0;
            sck_lvl_q  <= 1'b1;
            done_q     <= 1'b0;
        end else begin
            done_q  <= 1'b0;
            timer_q <= timer_q + 1'b1;
            unique case (state_q)
                asr_pkg::ASR_D_POR: begin
                    if (por_end) begin
                        timer_q <= '0;
                        state_q <= asr_pkg::ASR_D_CONVERT;
                    end
                end
                asr_pkg::ASR_D_CONVERT: begin
                    if (cs_fall) begin
                        sck_lvl_q <= 1'b0;              // Internal clocking pulls SCK low on select fall
                    end
                    if (hit(timer_q, CONV_CYCLES)) begin
                        // Finish regardless of select and load result as flag falls
                        shreg_q   <= {`ASR_EOC_READY, i_result};
                        sck_lvl_q <= 1'b0;
                        timer_q   <= '0;
                        state_q   <= asr_pkg::ASR_D_SLEEP;
                    end
                end
                asr_pkg::ASR_D_SLEEP: begin
                    if (cs_s_q) begin
                        timer_q <= '0;                  // Early select rise keeps sleep and result
                    end else if (ext_q) begin
                        timer_q <= '0;
                        if (sck_rise) begin
                            rise_cnt_q <= `ASR_CNT_W'(1);          // Wake only on SCK rise
                            state_q    <= asr_pkg::ASR_D_OUTPUT;
                        end
                    end else begin
                        if (cs_fall) begin
                            sck_lvl_q <= 1'b0;
                        end
                        if (hit(timer_q, `ASR_TEST_DLY_CYC)) begin
                            // Counted from select fall or flag fall, whichever came last
                            sck_lvl_q  <= 1'b1;
                            rise_cnt_q <= `ASR_CNT_W'(1);
                            timer_q    <= '0;
                            state_q    <= asr_pkg::ASR_D_OUTPUT;
                        end
                    end
                end
                asr_pkg::ASR_D_OUTPUT: begin
                    if (cs_rise) begin
                        // Mid-frame select rise aborts and restarts conversion
                        timer_q <= '0;
                        state_q <= asr_pkg::ASR_D_CONVERT;
                    end else if (ext_q) begin
                        if (sck_rise) begin
                            rise_cnt_q <= rise_cnt_q + 1'b1;
                        end else if (sck_fall) begin
                            if (frame_full) begin
                                done_q  <= 1'b1;        // 32nd fall starts next conversion
                                timer_q <= '0;
                                state_q <= asr_pkg::ASR_D_CONVERT;
                            end else begin
                                shreg_q <= {shreg_q[`ASR_FRAME_BITS-2:0], 1'b0};  // Next bit on fall
                            end
                        end
                    end else if (hit(timer_q, `ASR_SCK_HALF)) begin
                        // Half period of four clocks gives SCK at clock over eight
                        timer_q <= '0;
                        if (sck_lvl_q && frame_full) begin
                            done_q  <= 1'b1;            // SCK stays high into conversion
                            state_q <= asr_pkg::ASR_D_CONVERT;
                        end else if (sck_lvl_q) begin
                            sck_lvl_q <= 1'b0;
                            shreg_q   <= {shreg_q[`ASR_FRAME_BITS-2:0], 1'b0};
                        end else begin
                            sck_lvl_q  <= 1'b1;
                            rise_cnt_q <= rise_cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= asr_pkg::ASR_D_POR;
                end
            endcase
        end
    end

    // Pin drivers, all registered
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sdo_oe_q <= 1'b0;
            sdo_q    <= `ASR_EOC_BUSY;
            sck_oe_q <= 1'b0;
            sck_o_q  <= 1'b1;
        end else begin
            sdo_oe_q <= ~cs_s_q;                        // Released while select high
            if (state_q == asr_pkg::ASR_D_SLEEP || state_q == asr_pkg::ASR_D_OUTPUT) begin
                sdo_q <= shreg_q[`ASR_FLAG_BIT];        // Flag low in sleep, then frame bits
            end else begin
                sdo_q <= `ASR_EOC_BUSY;                 // Flag high while converting
            end
            // Internal clocking drives SCK only while selected
            sck_oe_q <= ~ext_q && ~cs_s_q && (state_q != asr_pkg::ASR_D_POR);
            sck_o_q  <= sck_lvl_q;
        end
    end

    // Status outputs
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q <= 1'b1;
        end else begin
            busy_q <= (state_q != asr_pkg::ASR_D_SLEEP) && (state_q != asr_pkg::ASR_D_OUTPUT);
        end
    end

    assign lk.sdo_o       = sdo_q;
    assign lk.sdo_oe      = sdo_oe_q;
    assign lk.dev_sck_o   = sck_o_q;
    assign lk.dev_sck_oe  = sck_oe_q;
    assign lk.sck_pullup  = pullup_q;
    assign o_busy         = busy_q;
    assign o_ext_sck      = ext_q;
    assign o_frame_done   = done_q;

endmodule

// ### rtl/asr_host.sv
// Host end: selects clock source, checks status and reads 32-bit frames
`timescale 1ns/1ps
`include "asr_params.svh"
module asr_host (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // Link
    asr_link_if.host         lk,
    // User request side
    input  wire logic        i_read,
    input  wire logic        i_abort,
    input  wire logic        i_ext_sck,
    // User answer side
    output logic [31:0]      o_data,
    output logic             o_valid,
    output logic             o_busy
);

    asr_pkg::asr_host_state_e        state_q;
    logic [`ASR_TIMER_W-1:0]         timer_q;
    logic [`ASR_CNT_W-1:0]           cnt_q;
    logic                            ext_q;
    logic                            cs_n_q;
    logic                            sck_o_q;
    logic                            sck_oe_q;
    logic [31:0]                     data_q;
    logic [31:0]                     data_out_q;
    logic                            valid_q;
    logic                            busy_q;
    logic                            sdo_m_q, sdo_s_q;
    logic                            sck_m_q, sck_s_q, sck_p_q;
    logic                            sck_rise;

    // Timer end test used by the setup and half-period states
    function automatic logic hit(input logic [`ASR_TIMER_W-1:0] t, input int unsigned n);
        hit = (t == `ASR_TIMER_W'(n - 1));
    endfunction

    // Pin inputs pass two flip-flops
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sdo_m_q <= 1'b1;
            sdo_s_q <= 1'b1;
            sck_m_q <= 1'b1;
            sck_s_q <= 1'b1;
            sck_p_q <= 1'b1;
        end else begin
            sdo_m_q <= lk.sdo;
            sdo_s_q <= sdo_m_q;
            sck_m_q <= lk.sck;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
        end
    end

    assign sck_rise = sck_s_q & ~sck_p_q;

    // Transfer sequencer
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q  <= asr_pkg::ASR_H_IDLE;
            timer_q  <= '0;
            cnt_q    <= '0;
            ext_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            sck_o_q  <= 1'b0;
            sck_oe_q <= 1'b0;
            data_q   <= '0;
            data_out_q <= '0;
            valid_q  <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            timer_q <= timer_q + 1'b1;
            unique case (state_q)
                asr_pkg::ASR_H_IDLE: begin
                    cs_n_q   <= 1'b1;
                    ext_q    <= i_ext_sck;
                    sck_o_q  <= 1'b0;
                    sck_oe_q <= i_ext_sck;              // Hold SCK low through power-up only when i_ext_sck asks for external clocking
                    timer_q  <= '0;
                    cnt_q    <= '0;
                    if (i_read) begin
                        state_q <= asr_pkg::ASR_H_SETUP;
                    end
                end
                asr_pkg::ASR_H_SETUP: begin
                    // SCK level settles before the chip select fall
                    if (hit(timer_q, `ASR_HOST_SETUP)) begin
                        cs_n_q  <= 1'b0;
                        timer_q <= '0;
                        state_q <= asr_pkg::ASR_H_WAIT;
                    end
                end
                asr_pkg::ASR_H_WAIT: begin
                    if (i_abort) begin
                        cs_n_q  <= 1'b1;                // Status check ends before output
                        state_q <= asr_pkg::ASR_H_IDLE;
                    end else if (timer_q >= `ASR_TIMER_W'(`ASR_HOST_GUARD)) begin
                        if (!ext_q) begin
                            state_q <= asr_pkg::ASR_H_RUN;
                        end else if (sdo_s_q == `ASR_EOC_READY) begin
                            sck_o_q <= 1'b1;
                            data_q  <= {data_q[30:0], sdo_s_q};   // Flag taken at first rise
                            cnt_q   <= `ASR_CNT_W'(1);
                            timer_q <= '0;
                            state_q <= asr_pkg::ASR_H_HIGH;
                        end
                    end
                end
                asr_pkg::ASR_H_HIGH: begin
                    if (hit(timer_q, `ASR_HOST_HALF)) begin
                        sck_o_q <= 1'b0;
                        timer_q <= '0;
                        state_q <= asr_pkg::ASR_H_LOW;
                    end
                end
                asr_pkg::ASR_H_LOW: begin
                    if (i_abort) begin
                        cs_n_q  <= 1'b1;                // Abort inside the frame
                        state_q <= asr_pkg::ASR_H_IDLE;
                    end else if (hit(timer_q, `ASR_HOST_HALF)) begin
                        timer_q <= '0;
                        if (cnt_q == `ASR_CNT_W'(`ASR_FRAME_BITS)) begin
                            // Select stays low past the 32nd fall so the device ends the frame first
                            data_out_q <= data_q;
                            valid_q    <= 1'b1;
                            cs_n_q     <= 1'b1;
                            state_q    <= asr_pkg::ASR_H_IDLE;
                        end else begin
                            sck_o_q <= 1'b1;
                            data_q  <= {data_q[30:0], sdo_s_q};   // Capture on rising edge
                            cnt_q   <= cnt_q + 1'b1;
                            state_q <= asr_pkg::ASR_H_HIGH;
                        end
                    end
                end
                asr_pkg::ASR_H_RUN: begin
                    if (i_abort && (sck_s_q || cnt_q == '0)) begin
                        // Mid-frame only while SCK high; before the first rise it is a status
                        cs_n_q  <= 1'b1;
                        state_q <= asr_pkg::ASR_H_IDLE;
                    end else if (sck_rise) begin
                        data_q <= {data_q[30:0], sdo_s_q};        // Capture on rising edge
                        cnt_q  <= cnt_q + 1'b1;
                        if (cnt_q == `ASR_CNT_W'(`ASR_FRAME_BITS - 1)) begin
                            data_out_q <= {data_q[30:0], sdo_s_q};
                            valid_q    <= 1'b1;
                            cs_n_q     <= 1'b1;
                            state_q    <= asr_pkg::ASR_H_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= asr_pkg::ASR_H_IDLE;
                end
            endcase
        end
    end

    // Busy flag follows the sequencer
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q != asr_pkg::ASR_H_IDLE);
        end
    end

    assign lk.cs_n        = cs_n_q;
    assign lk.host_sck_o  = sck_o_q;
    assign lk.host_sck_oe = sck_oe_q;
    assign o_data         = data_out_q;
    assign o_valid        = valid_q;
    assign o_busy         = busy_q;

endmodule

// ### rtl/asr_link_if.sv
// Three-wire link between converter end and host end, with pin resolution
`timescale 1ns/1ps
interface asr_link_if;
    logic cs_n;         // Chip select, driven by host
    logic host_sck_o;   // Host SCK drive value
    logic host_sck_oe;  // Host SCK drive enable
    logic dev_sck_o;    // Device SCK drive value
    logic dev_sck_oe;   // Device SCK drive enable
    logic sck_pullup;   // Device weak pull-up enable
    logic sdo_o;        // Device SDO value
    logic sdo_oe;       // Device SDO enable
    logic sck;          // Resolved SCK level
    logic sdo;          // Resolved SDO level

    // Strong drivers win, the pull-up lifts an idle pin, an idle pin without it reads low
    assign sck = dev_sck_oe ? dev_sck_o : (host_sck_oe ? host_sck_o : sck_pullup);
    // Undriven SDO reads high, as with a bus keeper or pull-up on the board
    assign sdo = sdo_oe ? sdo_o : 1'b1;

    modport dev (
        input  cs_n, sck,
        output dev_sck_o, dev_sck_oe, sck_pullup, sdo_o, sdo_oe
    );

    modport host (
        input  sck, sdo,
        output cs_n, host_sck_o, host_sck_oe
    );
endinterface

// ### rtl/asr_params.svh
// Timing counts, frame layout and pin defaults for the serial readout link
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// System clock
`define ASR_CLK_PERIOD_NS 10

// Frame layout: completion flag leads, 32 bits in all
`define ASR_FRAME_BITS    32
`define ASR_CNT_W         6
`define ASR_FLAG_BIT      31
`define ASR_EOC_BUSY      1'b1
`define ASR_EOC_READY     1'b0

// Power-on reset interval, 0.5 ms, rounded down to cycles
`define ASR_POR_TIME_US   500
`define ASR_POR_CYC       ((`ASR_POR_TIME_US * 1000) / `ASR_CLK_PERIOD_NS)

// Status test delay before internal clocking starts, least time so rounded up
`define ASR_TEST_DLY_NS   23000
`define ASR_TEST_DLY_CYC  ((`ASR_TEST_DLY_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)

// Internal serial clock: conversion clock divided by eight
`define ASR_SCK_DIV       8
`define ASR_SCK_HALF      (`ASR_SCK_DIV / 2)

// Stand-in conversion time in cycles
`define ASR_CONV_CYC      1000

// Host side: external clock half period and setup before chip select falls
`define ASR_HOST_HALF     8
`define ASR_HOST_SETUP    2
`define ASR_HOST_GUARD    4

// Width of the shared interval timers
`define ASR_TIMER_W       20

`endif

// ### rtl/asr_pkg.sv
// Types shared by both ends of the serial readout link
package asr_pkg;

    // Device sequencing states
    typedef enum logic [3:0] {
        ASR_D_POR     = 4'h1,
        ASR_D_CONVERT = 4'h2,
        ASR_D_SLEEP   = 4'h4,
        ASR_D_OUTPUT  = 4'h8
    } asr_dev_state_e;

    // Host transfer states
    typedef enum logic [5:0] {
        ASR_H_IDLE  = 6'h01,
        ASR_H_SETUP = 6'h02,
        ASR_H_WAIT  = 6'h04,
        ASR_H_HIGH  = 6'h08,
        ASR_H_LOW   = 6'h10,
        ASR_H_RUN   = 6'h20
    } asr_host_state_e;

endpackage

// ### tb/asr_link_assertions.sv
// Pin checks of the serial readout link
`timescale 1ns/1ps
module asr_link_assertions (
    // Clock and reset
    input logic i_clock,
    input logic i_nrst,
    // Link pins
    input logic cs_n,
    input logic sck,
    input logic sck_pullup,
    input logic sdo_o,
    input logic sdo_oe,
    input logic dev_sck_oe,
    input logic host_sck_oe
);
    logic [5:0] rise_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // SCK rises within one selection
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) rise_q <= 6'h00;
        else if (cs_n) rise_q <= 6'h00;
        else if ($rose(sck)) rise_q <= rise_q + 6'h01;
    end
    // A new conversion shows as a high flag soon
    sequence s_conv;
        ##[1:8] sdo_o;
    endsequence
    a_sdo_hiz_deselect: assert property (cs_n [*5] |-> !sdo_oe) else $error("sdo driven");
    a_flag_on_select: assert property (!cs_n [*6] |-> sdo_oe) else $error("sdo idle");
    a_pullup_off_low: assert property ((!sck && !cs_n) [*6] |-> !sck_pullup) else $error("pull-up on");
    a_sck_half_period: assert property ($fell(sck) && dev_sck_oe && $past(dev_sck_oe) |-> $past(sck, 4))
        else $error("sck high short");
    a_sdo_change_low: assert property ($changed(sdo_o) && sdo_oe && !cs_n && host_sck_oe |-> !sck)
        else $error("sdo moved");
    a_int_frame_end: assert property (dev_sck_oe && $rose(sck) && rise_q == 6'h1F |-> sck throughout s_conv)
        else $error("int end");
    a_ext_frame_end: assert property (host_sck_oe && !cs_n && $fell(sck) && rise_q == 6'h20 |-> s_conv)
        else $error("ext end");
    a_abort_converts: assert property ($rose(cs_n) && rise_q inside {[6'h01:6'h1F]} |-> s_conv)
        else $error("abort");
endmodule

// ### tb/test_adc_serial_readout_timing.sv
// Bench joining both ends: frames in both clock modes, a status check, an abort
`timescale 1ns/1ps
module test_adc_serial_readout_timing;
    logic        clock;
    logic        nrst;
    logic        rd, abrt, ext, valid, dbusy, dext, fdone, hbusy;
    int          dones;
    logic [30:0] res;
    logic [31:0] data;
    int          err_total, checked, n;
    asr_link_if lk ();
    asr_dev #(.POR_CYCLES(20), .CONV_CYCLES(50)) asr_dev_inst (.i_clock(clock), .i_nrst(nrst), .lk(lk),
        .i_result(res), .o_busy(dbusy), .o_ext_sck(dext), .o_frame_done(fdone));
    asr_host asr_host_inst (.i_clock(clock), .i_nrst(nrst), .lk(lk), .i_read(rd), .i_abort(abrt),
        .i_ext_sck(ext), .o_data(data), .o_valid(valid), .o_busy(hbusy));
    asr_link_assertions asr_link_assertions_inst (.i_clock(clock), .i_nrst(nrst), .cs_n(lk.cs_n), .sck(lk.sck),
        .sck_pullup(lk.sck_pullup), .sdo_o(lk.sdo_o), .sdo_oe(lk.sdo_oe), .dev_sck_oe(lk.dev_sck_oe),
        .host_sck_oe(lk.host_sck_oe));
    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Count finished frames away from the launching edge
    always @(negedge clock) begin
        if (fdone === 1'b1) dones++;
    end
    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) err_total++;
        if (got !== exp) $display("ERROR %s expected %h seen %h", what, exp, got);
    endtask
    // Counts, verdict, stop
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Wait for sleep, request a frame, abort after stop_at cycles if no answer
    task automatic read_frame(input logic use_ext, input int stop_at);
        ext = use_ext;
        repeat (8) @(negedge clock);
        for (n = 0; dbusy !== 1'b0 && n < 5000; n++) @(negedge clock);
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        for (n = 0; valid !== 1'b1 && n < 5000 && n != stop_at; n++) @(negedge clock);
        abrt = (n == stop_at);
        @(negedge clock);
        abrt = 1'b0;
    endtask
    // Full frame: data, clock source, length; then next result
    task automatic frame_check(input logic use_ext, input logic [30:0] exp, input logic [30:0] nxt);
        read_frame(use_ext, -1);
        check("data", {1'b0, exp}, data);
        check("ext_sck", {31'h0, use_ext}, {31'h0, dext});
        check("length", {31'h0, !use_ext}, {31'h0, n > 2300});
        check("host_busy", 32'h0000_0000, {31'h0, hbusy});
        res = nxt;
    endtask
    // Main sequence
    initial begin
        nrst = 1'b0;
        rd = 1'b0;
        abrt = 1'b0;
        ext = 1'b0;
        res = 31'h5A3C_0F96;
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        frame_check(1'b0, 31'h5A3C_0F96, 31'h1234_5678);
        read_frame(1'b0, 200);
        res = 31'h0C3A_91E7;
        frame_check(1'b0, 31'h1234_5678, 31'h0C3A_91E7);
        frame_check(1'b1, 31'h0C3A_91E7, 31'h7F00_00FF);
        read_frame(1'b1, 100);
        frame_check(1'b1, 31'h7F00_00FF, 31'h7F00_00FF);
        check("frames_done", 32'h0000_0004, dones);
        tally_and_finish();
    end
    // Watchdog well past the expected run
    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        $display("ERROR watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
